// ==== logic/lcd_panel_pin_interface.sv ====
// Added by the designer: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Pin interface toward an LCD panel or an external LCD controller.
module lcd_panel_pin_interface #(
  parameter int buf_depth = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite register port.
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Pixel stream, one panel word per item, data line n on bit n; the 8-bit mapping swaps the two nibbles.
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [7:0] pix_data,
  // Pixel rate clock from outside the clock domain.
  input wire logic pixel_rate_clock,
  // Panel pins.
  output logic panel_shift_clock,
  input wire logic panel_load_clock_i,
  output logic panel_load_clock_o,
  output logic panel_load_clock_oe,
  input wire logic panel_first_line_clock_i,
  output logic panel_first_line_clock_o,
  output logic panel_first_line_clock_oe,
  output logic [7:0] panel_pixel_data,
  output logic panel_logic_power_ctrl,
  output logic panel_bias_power_ctrl,
  // Side-band results for the rest of the chip.
  output logic compressed_isa_enable_strap,
  output logic mem_sixteen_bit_size_n
);
  import lcd_pin_pkg::*;

  // Software-visible state.
  ctrl_type ctrl_q;
  logic [9:0] line_len_q;
  logic [9:0] frame_lines_q;
  status_type status;

  // Synchronisers for the three inputs from outside the domain.
  logic prc_s1_q, prc_s2_q, prc_s3_q;
  logic load_s1_q, load_s2_q;
  logic flm_s1_q, flm_s2_q;

  // AXI bookkeeping.
  logic aw_held_q, w_held_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // Shifter state.
  logic [9:0] pix_count_q;
  logic [9:0] line_count_q;
  logic word_shown_q;
  logic load_pulse_q;
  logic shift_q;
  logic [7:0] word_q;
  logic strap_q;
  logic run_q;

  // Buffer output side.
  logic buf_valid;
  logic [7:0] buf_data;

  // The synchronisers carry no reset so they track the pins during reset.
  always_ff @(posedge aclk)
  begin
    if (ce)
    begin
      prc_s1_q <= pixel_rate_clock;
      prc_s2_q <= prc_s1_q;
      prc_s3_q <= prc_s2_q;
      load_s1_q <= panel_load_clock_i;
      load_s2_q <= load_s1_q;
      flm_s1_q <= panel_first_line_clock_i;
      flm_s2_q <= flm_s1_q;
    end
  end

  // Strap capture while reset is held; the value stays after release.
  always_ff @(posedge aclk)
  begin
    if (!aresetn && ce)
    begin
      strap_q <= flm_s2_q;
    end
  end

  // Pixel rate clock edges, seen from the second and third stages only.
  wire prc_rise = prc_s2_q && !prc_s3_q;
  wire prc_fall = !prc_s2_q && prc_s3_q;

  // A word is taken from the buffer on a rising pixel edge while running.
  wire take_word = ce && run_q && prc_rise && buf_valid;
  wire last_pixel = (pix_count_q == line_len_q - 10'h001);
  wire last_line = (line_count_q == frame_lines_q - 10'h001);

  pixel_skid_buffer #(
    .width(8),
    .depth(buf_depth)
  ) u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data(pix_data),
    .out_valid(buf_valid),
    .out_ready(take_word),
    .out_data(buf_data)
  );

  // Panel data mapping; a receiver stall simply leaves words in the buffer.
  wire [3:0] low_nibble = ctrl_q.wide_panel ? word_q[7:4] : word_q[3:0];
  wire [3:0] panel_high = ctrl_q.wide_panel ? word_q[3:0] : 4'h0;
  wire [3:0] high_nibble = ctrl_q.high_data_is_gpio ? ctrl_q.gpio_high : panel_high;
  wire shift_pin_d = ctrl_q.shift_is_select ? !ctrl_q.select_assert : shift_q;
  wire logic_pin_d = ctrl_q.logic_is_general ? ctrl_q.gen_out_one : ctrl_q.logic_power;
  wire bias_pin_d = ctrl_q.bias_is_general ? ctrl_q.gen_out_zero : ctrl_q.bias_power;

  // Address decode for both channels.
  wire wr_fire = aw_held_q && w_held_q && !s_bvalid;
  wire wr_ctrl = (awaddr_q == ctrl_offset);
  wire wr_geom = (awaddr_q == geom_offset);
  wire wr_known = wr_ctrl || wr_geom || (awaddr_q == status_offset);
  wire rd_fire = s_arvalid && s_arready;
  wire rd_known = (s_araddr == ctrl_offset) || (s_araddr == geom_offset) || (s_araddr == status_offset);
  wire [31:0] geom_word = {6'h00, frame_lines_q, 6'h00, line_len_q};
  wire [31:0] rd_word = (s_araddr == ctrl_offset) ? {16'h0000, ctrl_q} :
                        (s_araddr == geom_offset) ? geom_word :
                        (s_araddr == status_offset) ? {28'h0000000, status} : 32'h00000000;

  // Byte-lane merge of a write into the current register word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  wire [31:0] ctrl_new = merge({16'h0000, ctrl_q}, wdata_q, wstrb_q);
  wire [31:0] geom_new = merge(geom_word, wdata_q, wstrb_q);

  assign status.isa_strap = strap_q;
  assign status.mem_size_n = mem_sixteen_bit_size_n;
  assign status.buffer_has_data = buf_valid;
  assign status.frame_first_line = (line_count_q == 10'h000);

  // Write address and data are held separately, then answered together.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= resp_okay;
      ctrl_q <= ctrl_reset;
      line_len_q <= line_len_reset;
      frame_lines_q <= frame_lines_reset;
    end
    else if (ce)
    begin
      // Ready is offered only while the matching holder is empty.
      s_awready <= !aw_held_q && !(s_awvalid && s_awready);
      s_wready <= !w_held_q && !(s_wvalid && s_wready);
      if (s_awvalid && s_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_wdata;
        wstrb_q <= s_wstrb;
      end
      if (wr_fire)
      begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_known ? resp_okay : resp_slverr;
        // The status register ignores writes; unknown offsets report an error.
        if (wr_ctrl)
        begin
          ctrl_q <= ctrl_new[15:0];
        end
        if (wr_geom)
        begin
          line_len_q <= geom_new[geom_line_lsb +: 10];
          frame_lines_q <= geom_new[geom_lines_lsb +: 10];
        end
      end
      else if (s_bvalid && s_bready)
      begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one read at a time, answered the cycle after it is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= resp_okay;
    end
    else if (ce)
    begin
      s_arready <= !s_rvalid && !rd_fire;
      if (rd_fire)
      begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_word;
        s_rresp <= rd_known ? resp_okay : resp_slverr;
      end
      else if (s_rvalid && s_rready)
      begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // Pixel shifter: data changes on a rising pixel edge, the shift clock
  // rises on the following falling edge, and a line ends with a load pulse.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_q <= 1'b0;
      pix_count_q <= 10'h000;
      line_count_q <= 10'h000;
      word_shown_q <= 1'b0;
      load_pulse_q <= 1'b0;
      shift_q <= 1'b0;
      word_q <= 8'h00;
    end
    else if (ce)
    begin
      // Enable changes only act between pixel periods to avoid runt clocks.
      if (prc_rise)
      begin
        run_q <= ctrl_q.enable;
      end
      if (take_word)
      begin
        word_q <= buf_data;
        shift_q <= 1'b0;
        word_shown_q <= 1'b1;
      end
      else if (prc_fall)
      begin
        if (load_pulse_q)
        begin
          load_pulse_q <= 1'b0;
        end
        if (word_shown_q)
        begin
          shift_q <= 1'b1;
          word_shown_q <= 1'b0;
          if (last_pixel)
          begin
            pix_count_q <= 10'h000;
            load_pulse_q <= 1'b1;
            line_count_q <= last_line ? 10'h000 : line_count_q + 10'h001;
          end
          else
          begin
            pix_count_q <= pix_count_q + 10'h001;
          end
        end
      end
      if (!run_q)
      begin
        shift_q <= 1'b0;
        pix_count_q <= 10'h000;
        line_count_q <= 10'h000;
        load_pulse_q <= 1'b0;
      end
    end
  end

  // Pin drivers, every one a flip-flop.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      panel_shift_clock <= 1'b1;
      panel_load_clock_o <= 1'b0;
      panel_load_clock_oe <= 1'b0;
      panel_first_line_clock_o <= 1'b0;
      panel_first_line_clock_oe <= 1'b0;
      panel_pixel_data <= 8'h00;
      panel_logic_power_ctrl <= 1'b0;
      panel_bias_power_ctrl <= 1'b0;
      compressed_isa_enable_strap <= 1'b0;
      mem_sixteen_bit_size_n <= 1'b1;
    end
    else if (ce)
    begin
      panel_shift_clock <= shift_pin_d;
      panel_load_clock_o <= load_pulse_q;
      panel_load_clock_oe <= !ctrl_q.load_is_mem_size;
      // Far side drives the pin low for 16-bit memory cycles when selected.
      mem_sixteen_bit_size_n <= ctrl_q.load_is_mem_size ? load_s2_q : 1'b1;
      // Frame start marks the load pulse that closes the frame's last line.
      panel_first_line_clock_o <= load_pulse_q && (line_count_q == 10'h000);
      panel_first_line_clock_oe <= 1'b1;
      panel_pixel_data <= {high_nibble, low_nibble};
      panel_logic_power_ctrl <= logic_pin_d;
      panel_bias_power_ctrl <= bias_pin_d;
      compressed_isa_enable_strap <= strap_q;
    end
  end
endmodule
`default_nettype wire

// ==== logic/lcd_pin_pkg.sv ====
package lcd_pin_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [3:0] ctrl_offset = 4'h0;
  localparam logic [3:0] geom_offset = 4'h4;
  localparam logic [3:0] status_offset = 4'h8;

  // Reset values; all pin selects are zero, which is the panel function.
  localparam logic [15:0] ctrl_reset = 16'h0000;
  localparam logic [9:0] line_len_reset = 10'h140;
  localparam logic [9:0] frame_lines_reset = 10'h0f0;

  // Field positions inside the geometry register.
  localparam int geom_line_lsb = 0;
  localparam int geom_lines_lsb = 16;

  // AXI response codes.
  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  // Control register layout, bit 15 downward.
  typedef struct packed {
    logic [3:0] gpio_high;        // Levels for general pins 15:12.
    logic gen_out_zero;           // General output level on the bias pin.
    logic gen_out_one;            // General output level on the logic power pin.
    logic bias_power;             // Panel bias power control level.
    logic logic_power;            // Panel logic power control level.
    logic bias_is_general;        // Bias pin used as general output.
    logic logic_is_general;       // Logic power pin used as general output.
    logic high_data_is_gpio;      // Pixel outputs 7:4 used as general pins.
    logic load_is_mem_size;       // Load pin used as the memory sizing input.
    logic select_assert;          // Assert the external-controller select.
    logic shift_is_select;        // Shift pin used as the select.
    logic wide_panel;             // High selects the 8-bit mapping.
    logic enable;                 // Runs the pixel shifter.
  } ctrl_type;

  // Status bits shown to software.
  typedef struct packed {
    logic frame_first_line;       // The shifter is on the first line.
    logic buffer_has_data;        // The pixel buffer holds a word.
    logic mem_size_n;             // Synchronised memory sizing input.
    logic isa_strap;              // Compressed-ISA strap caught in reset.
  } status_type;

endpackage

// ==== logic/pixel_skid_buffer.sv ====
`timescale 1ns/1ps
`default_nettype none
// Small first-in first-out buffer with valid and ready on both sides.
module pixel_skid_buffer #(
  parameter int width = 8,
  parameter int depth = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [width-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [width-1:0] out_data
);
  localparam int ptr_w = (depth > 2) ? $clog2(depth) : 1;
  // Depth at the width of the occupancy count.
  localparam logic [ptr_w:0] depth_c = (ptr_w + 1)'(depth);

  // Storage entries and pointers.
  logic [width-1:0] mem_q [depth];
  logic [ptr_w-1:0] wr_q;
  logic [ptr_w-1:0] rd_q;
  logic [ptr_w:0] count_q;

  wire push = ce && in_valid && in_ready;
  wire pop = ce && out_valid && out_ready;
  // Occupancy after this cycle's push and pop.
  wire [ptr_w:0] count_d = count_q + {{ptr_w{1'b0}}, push} - {{ptr_w{1'b0}}, pop};

  // Empty comes from the count; ready is a flop fed by the next count, so the
  // top's ready pin is registered yet still drops in the cycle the buffer fills.
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_q];

  // Pointers wrap at the depth, which need not be a power of two.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= (wr_q == ptr_w'(depth - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= (rd_q == ptr_w'(depth - 1)) ? '0 : rd_q + 1'b1;
      end
      // A push and a pop in one cycle leave the count as it is.
      count_q <= count_d;
      in_ready <= (count_d < depth_c);
    end
  end

  // The data array needs no reset; the count guards every read.
  always_ff @(posedge aclk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ==== verif/lcd_pin_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// Follows the control word from bus writes and checks the pins against it.
module lcd_pin_properties
  import lcd_pin_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  input wire logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic s_wvalid,
  input wire logic s_wready,
  input wire logic s_bvalid,
  input wire logic panel_shift_clock,
  input wire logic panel_load_clock_i,
  input wire logic panel_load_clock_oe,
  input wire logic panel_first_line_clock_oe,
  input wire logic [7:0] panel_pixel_data,
  input wire logic panel_logic_power_ctrl,
  input wire logic panel_bias_power_ctrl,
  input wire logic compressed_isa_enable_strap,
  input wire logic mem_sixteen_bit_size_n
);
  ctrl_type c_q; // Control word as last written.
  logic [31:0] w_q; // Data of the write in flight.
  logic [3:0] a_q; // Address of the write in flight.
  logic [3:0] n_q; // Cycles since the last write address.
  logic b_q; // Response valid one cycle ago.
  wire logic ok = n_q == 4'hf; // Pins have had time to follow a new word.
  // The count restarts at each write, since pins lag the register by a few cycles.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      c_q <= ctrl_reset;
      n_q <= 4'h0;
      b_q <= 1'b0;
    end
    else
    begin
      b_q <= s_bvalid;
      n_q <= (s_awvalid && s_awready) ? 4'h0 : (ok ? n_q : n_q + 4'h1);
      if (s_awvalid && s_awready) a_q <= s_awaddr;
      if (s_wvalid && s_wready) w_q <= s_wdata;
      if (s_bvalid && !b_q && a_q == ctrl_offset) c_q <= w_q[15:0];
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence size_held_low;
    (ok && ce && c_q.load_is_mem_size && !panel_load_clock_i)[*4];
  endsequence
  sequence running_a_while;
    aresetn[*3];
  endsequence
  // The strap output takes strap_q on the first edge after release and keeps that value, so two quiet cycles are needed.
  chk_strap_kept: assert property (aresetn && $past(aresetn) && $past(aresetn, 2)
    |-> $stable(compressed_isa_enable_strap))
    else $error("strap changed outside reset");
  chk_first_line_driven: assert property (running_a_while |-> panel_first_line_clock_oe)
    else $error("first line pin not driven");
  chk_narrow_high_zero: assert property (ok && !c_q.wide_panel && !c_q.high_data_is_gpio |-> panel_pixel_data[7:4] == 4'h0)
    else $error("high pixel pins busy on narrow panel");
  chk_gpio_high_pins: assert property (ok && c_q.high_data_is_gpio |-> panel_pixel_data[7:4] == c_q.gpio_high)
    else $error("general pins wrong");
  chk_select_level: assert property (ok && c_q.shift_is_select |-> panel_shift_clock == !c_q.select_assert)
    else $error("select level wrong");
  chk_logic_power: assert property (ok |-> panel_logic_power_ctrl == (c_q.logic_is_general ? c_q.gen_out_one : c_q.logic_power))
    else $error("logic power pin wrong");
  chk_bias_power: assert property (ok |-> panel_bias_power_ctrl == (c_q.bias_is_general ? c_q.gen_out_zero : c_q.bias_power))
    else $error("bias power pin wrong");
  chk_size_follows: assert property (size_held_low |-> !mem_sixteen_bit_size_n)
    else $error("sizing input not seen");
  chk_load_drive: assert property (ok |-> panel_load_clock_oe == !c_q.load_is_mem_size)
    else $error("load pin direction wrong");
endmodule
bind lcd_panel_pin_interface lcd_pin_properties i_lcd_pin_properties (.aclk, .aresetn, .ce, .s_awaddr, .s_awvalid,
  .s_awready, .s_wdata, .s_wvalid, .s_wready, .s_bvalid, .panel_shift_clock, .panel_load_clock_i,
  .panel_load_clock_oe, .panel_first_line_clock_oe, .panel_pixel_data, .panel_logic_power_ctrl,
  .panel_bias_power_ctrl, .compressed_isa_enable_strap, .mem_sixteen_bit_size_n);
`default_nettype wire

// ==== verif/lcd_panel_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Panel and bus agent on the far side of the pins.
module lcd_panel_model (
  input wire logic strap_level,
  input wire logic size_req,
  input wire logic panel_shift_clock,
  input wire logic panel_load_clock_o,
  input wire logic panel_load_clock_oe,
  input wire logic panel_first_line_clock_o,
  input wire logic panel_first_line_clock_oe,
  input wire logic [7:0] panel_pixel_data,
  output logic load_wire,
  output logic first_line_wire
);
  logic [7:0] seen[$]; // Pixel pins taken at each shift edge.
  int frames = 0; // Frame starts seen.
  int lines = 0; // Line load pulses seen while the pin is driven.
  // The pull-up holds the pin high unless the agent asks for 16-bit width.
  assign load_wire = panel_load_clock_oe ? panel_load_clock_o : !size_req;
  // A strap resistor sets the level whenever the device lets go.
  assign first_line_wire = panel_first_line_clock_oe ? panel_first_line_clock_o : strap_level;
  // The panel latches its data lines on the rising shift edge.
  always @(posedge panel_shift_clock) seen.push_back(panel_pixel_data);
  always @(posedge first_line_wire) if (panel_first_line_clock_oe) frames++;
  always @(posedge panel_load_clock_o) if (panel_load_clock_oe) lines++;
endmodule
`default_nettype wire

// ==== verif/lcd_panel_pin_interface_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_pin_interface_test;
  import lcd_pin_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, pixel_rate_clock = 1'b0;
  logic ce = 1'b1; // Clock enable, dropped once to show that state freezes.
  wire logic [3:0] s_wstrb = 4'hf;
  logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0;
  logic [31:0] s_wdata = 32'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, pix_ready;
  logic [1:0] s_bresp, s_rresp, rsp;
  logic [31:0] s_rdata;
  logic pix_valid = 1'b0, strap_level = 1'b1, size_req = 1'b0, run_pix = 1'b0;
  logic [7:0] pix_data = 8'h0, panel_pixel_data;
  logic panel_shift_clock, panel_load_clock_i, panel_load_clock_o, panel_load_clock_oe;
  logic panel_first_line_clock_i, panel_first_line_clock_o, panel_first_line_clock_oe;
  logic panel_logic_power_ctrl, panel_bias_power_ctrl, compressed_isa_enable_strap, mem_sixteen_bit_size_n;
  logic [31:0] rnd = 32'h4cc698c4; // Fixed seed keeps runs repeatable.
  int err_total = 0, checks = 0, cycles = 0;
  lcd_panel_pin_interface #(.buf_depth(2)) i_lcd_panel_pin_interface (.aclk, .aresetn, .ce, .s_awaddr,
    .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
    .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready, .pix_valid, .pix_ready, .pix_data,
    .pixel_rate_clock, .panel_shift_clock, .panel_load_clock_i, .panel_load_clock_o, .panel_load_clock_oe,
    .panel_first_line_clock_i, .panel_first_line_clock_o, .panel_first_line_clock_oe, .panel_pixel_data,
    .panel_logic_power_ctrl, .panel_bias_power_ctrl, .compressed_isa_enable_strap, .mem_sixteen_bit_size_n);
  lcd_panel_model i_lcd_panel_model (.strap_level, .size_req, .panel_shift_clock, .panel_load_clock_o,
    .panel_load_clock_oe, .panel_first_line_clock_o, .panel_first_line_clock_oe, .panel_pixel_data,
    .load_wire(panel_load_clock_i), .first_line_wire(panel_first_line_clock_i));
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  // The pixel clock stands low between streams, as a panel source would.
  initial
  begin
    forever #62.5 pixel_rate_clock = run_pix ? ~pixel_rate_clock : 1'b0;
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected pins: a wide panel swaps the nibbles, a narrow one leaves the top idle.
  function automatic logic [7:0] pin_map(logic [7:0] d, logic wide);
    return wide ? {d[3:0], d[7:4]} : {4'h0, d[3:0]};
  endfunction
  task automatic chk(string what, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Address and data go out together; each drops when taken.
  task automatic wr(logic [3:0] a, logic [31:0] d, output logic [1:0] r);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end
    while (!s_bvalid);
    r = s_bresp;
    s_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic chk_rd(logic [3:0] a, logic [31:0] e, logic [1:0] er);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end
    while (!s_rvalid);
    chk("read data", e, s_rdata);
    chk("read resp", {30'h0, er}, {30'h0, s_rresp});
    s_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // The buffer fills while the pixel clock stands still, then drains in order.
  task automatic stream(logic wide, int n);
    logic [7:0] q[$];
    int k;
    int c;
    i_lcd_panel_model.seen.delete();
    for (int j = 0; j < n; j++)
    begin
      rnd = lfsr(rnd);
      q.push_back(rnd[7:0]);
    end
    k = 0;
    c = 0;
    pix_data <= q[0];
    pix_valid <= 1'b1;
    while (k < n)
    begin
      @(posedge aclk);
      c++;
      if (pix_valid && pix_ready)
      begin
        k++;
        if (k < n) pix_data <= q[k];
        else pix_valid <= 1'b0;
      end
      if (c == 12)
      begin
        chk("buffer fill", 2, k);
        run_pix = 1'b1;
      end
    end
    repeat (100) @(posedge aclk);
    run_pix = 1'b0;
    chk("pixel count", n, i_lcd_panel_model.seen.size());
    for (int j = 0; j < n && j < i_lcd_panel_model.seen.size(); j++)
      chk("pixel pins", pin_map(q[j], wide), i_lcd_panel_model.seen[j]);
  endtask
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      end_of_test;
    end
  end
  initial
  begin
    // Two resets, one with each strap level, the second after the first pass of register checks.
    for (int s = 1; s >= 0; s--)
    begin
      strap_level <= s[0];
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("strap", s, compressed_isa_enable_strap);
      chk("first line drive", 1, panel_first_line_clock_oe);
      chk_rd(ctrl_offset, 32'h0, resp_okay);
      chk_rd(geom_offset, {6'h0, frame_lines_reset, 6'h0, line_len_reset}, resp_okay);
      chk_rd(status_offset, 32'ha | s, resp_okay);
      chk_rd(4'hc, 32'h0, resp_slverr);
      wr(status_offset, 32'hf, rsp);
      chk("status write resp", resp_okay, rsp);
    end
    wr(geom_offset, 32'h00020004, rsp);
    chk_rd(geom_offset, 32'h00020004, resp_okay);
    // A write to an unmapped offset must be refused with an error response.
    wr(4'hc, 32'h0, rsp);
    chk("bad write resp", resp_slverr, rsp);
    for (int w = 0; w < 2; w++)
    begin
      wr(ctrl_offset, 32'h1 | 32'(w << 1), rsp);
      stream(w[0], 20);
    end
    // Forty words on four-word lines give ten line ends; every second one wraps the two-line frame.
    chk("frame starts", 5, i_lcd_panel_model.frames);
    chk("load pulses", 10, i_lcd_panel_model.lines);
    repeat (10)
    begin
      rnd = lfsr(rnd);
      size_req <= rnd[16];
      wr(ctrl_offset, {16'h0, rnd[15:1], 1'b0}, rsp);
      repeat (8) @(posedge aclk);
      if (rnd[2]) chk("select", !rnd[3], panel_shift_clock);
      chk("logic power", rnd[6] ? rnd[10] : rnd[8], panel_logic_power_ctrl);
      chk("bias power", rnd[7] ? rnd[11] : rnd[9], panel_bias_power_ctrl);
      if (rnd[5]) chk("general pins", rnd[15:12], panel_pixel_data[7:4]);
      chk("load drive", !rnd[4], panel_load_clock_oe);
      if (rnd[4]) chk("sizing", !rnd[16], mem_sixteen_bit_size_n);
    end
    // With the clock enable low the sizing path must hold, then follow once it rises.
    size_req <= 1'b0;
    wr(ctrl_offset, 32'h10, rsp);
    repeat (8) @(posedge aclk);
    ce <= 1'b0;
    size_req <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("frozen sizing", 1, mem_sixteen_bit_size_n);
    ce <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("sizing after enable", 0, mem_sixteen_bit_size_n);
    end_of_test;
  end
endmodule
`default_nettype wire
